//--- hw/pwr_status_consts.svh
// command codes, field positions, masks and reset values of the status bank
`ifndef PWR_STATUS_CONSTS_SVH
`define PWR_STATUS_CONSTS_SVH

`define CMD_CLEAR_ALL 8'h03
`define CMD_LOW_TRIP 8'h53
`define CMD_SUM_SHORT 8'h78
`define CMD_SUM_LONG 8'h79
`define CMD_VOLTAGE_GROUP_FLAG 8'h7A
`define CMD_CURRENT_GROUP_FLAG 8'h7B
`define CMD_INPUT 8'h7C
`define CMD_THERMAL 8'h7D
`define CMD_CML 8'h7E
`define CMD_VENDOR 8'h80
`define CMD_ECC_INFO 8'hB6
`define CMD_PADS 8'hE5
`define CMD_COMMON 8'hEF

`define SUM_BUSY 7
`define SUM_OFF 6
`define SUM_OV 5
`define SUM_OC 4
`define SUM_TEMP 2
`define SUM_CML 1
`define SUM_UNLISTED 0
`define SUM_W1C_MASK 8'h81

`define WORD_VOLTAGE_GROUP_FLAG 7
`define WORD_CURRENT_GROUP_FLAG 6
`define WORD_INPUT 5
`define WORD_VENDOR 4
`define WORD_PG_N 3

`define OVERVOLTAGE_TRIP_FLAG_FAULT 7
`define VOLTAGE_GROUP_FLAG_MASK 8'hFE
`define OVERCURRENT_TRIP_FLAG_FAULT 7
`define CURRENT_GROUP_FLAG_MASK 8'hA0
`define INPUT_MASK 8'hA0
`define INPUT_W1C_MASK 8'h80
`define INPUT_LOW_OFF 3
`define THERMAL_UT_FAULT 4
`define THERMAL_MASK 8'hC0
`define CML_BAD_CMD 7
`define CML_BAD_DATA 6
`define CML_MASK 8'hFB
`define VENDOR_MASK 8'hFB
`define PADS_MASK 16'hCFFF
`define COMMON_MASK 8'h7A
`define COMMON_NO_ALERT 7
`define ECC_INFO_MASK 16'h0020

`define LOW_TRIP_RESET 16'hE580

`endif

//--- hw/pwr_status_pkg.sv
// types shared by the power status bank
package pwr_status_pkg;
	typedef logic [7:0] flag_byte_t;
	typedef logic [15:0] status_word_t;
endpackage

//--- hw/status_channel.sv
// per-channel sticky fault flags and low temperature trip level
`timescale 1ns/1ns
`include "pwr_status_consts.svh"
module status_channel
	import pwr_status_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic clear_all,
	input wire logic [15:0] wdata,
	input wire logic wr_sum,
	input wire logic wr_voltage_group_flag,
	input wire logic wr_current_group_flag,
	input wire logic wr_thermal,
	input wire logic wr_vendor,
	input wire logic wr_trip,
	input wire logic [7:0] voltage_group_flag_cond,
	input wire logic [7:0] current_group_flag_cond,
	input wire logic [7:0] thermal_cond,
	input wire logic [7:0] vendor_cond,
	input wire logic busy_evt,
	input wire logic unlisted_evt,
	input wire logic [15:0] ext_temp,
	output flag_byte_t voltage_group_flag_flags,
	output flag_byte_t current_group_flag_flags,
	output flag_byte_t thermal_flags,
	output flag_byte_t vendor_flags,
	output logic busy_flag,
	output logic unlisted_flag,
	output status_word_t low_temp_trip_level
);
	// linear 5s/11s to signed fixed point with 16 fraction bits
	function automatic logic signed [47:0] lin_to_fix(input logic [15:0] v);
		logic signed [47:0] m;
		logic signed [5:0] e;
		m = 48'(signed'(v[10:0]));
		e = 6'(signed'(v[15:11])) + 6'sd16;
		lin_to_fix = m <<< e;
	endfunction

	// a condition still present sets its flag in the same cycle as a clear
	function automatic flag_byte_t sticky(input flag_byte_t cur, input flag_byte_t cond,
			input logic wr, input logic clr, input flag_byte_t wd, input flag_byte_t mask);
		flag_byte_t drop;
		drop = clr ? 8'hFF : (wr ? (wd & mask) : 8'h00);
		sticky = ((cur & ~drop) | cond) & mask;
	endfunction

	logic under_temp;
	flag_byte_t therm_in;
	flag_byte_t sum_w1c;
	flag_byte_t sum_in;
	flag_byte_t sum_next;

	assign under_temp = lin_to_fix(ext_temp) < lin_to_fix(low_temp_trip_level);
	assign therm_in = (thermal_cond & `THERMAL_MASK) | (8'(under_temp) << `THERMAL_UT_FAULT);
	assign sum_in = (8'(busy_evt) << `SUM_BUSY) | (8'(unlisted_evt) << `SUM_UNLISTED);
	assign sum_w1c = {busy_flag, 6'h00, unlisted_flag};
	assign sum_next = sticky(sum_w1c, sum_in, wr_sum, clear_all, wdata[7:0], `SUM_W1C_MASK);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			voltage_group_flag_flags <= 8'h00;
			current_group_flag_flags <= 8'h00;
			thermal_flags <= 8'h00;
			vendor_flags <= 8'h00;
			busy_flag <= 1'b0;
			unlisted_flag <= 1'b0;
			low_temp_trip_level <= `LOW_TRIP_RESET;
		end else begin
			voltage_group_flag_flags <= sticky(voltage_group_flag_flags, voltage_group_flag_cond, wr_voltage_group_flag, clear_all, wdata[7:0],
				`VOLTAGE_GROUP_FLAG_MASK);
			current_group_flag_flags <= sticky(current_group_flag_flags, current_group_flag_cond, wr_current_group_flag, clear_all, wdata[7:0],
				`CURRENT_GROUP_FLAG_MASK);
			thermal_flags <= sticky(thermal_flags, therm_in, wr_thermal, clear_all, wdata[7:0],
				`THERMAL_MASK | (8'h01 << `THERMAL_UT_FAULT));
			vendor_flags <= sticky(vendor_flags, vendor_cond, wr_vendor, clear_all, wdata[7:0],
				`VENDOR_MASK);
			busy_flag <= sum_next[`SUM_BUSY];
			unlisted_flag <= sum_next[`SUM_UNLISTED];
			if (wr_trip)
				low_temp_trip_level <= wdata;
		end
	end
endmodule // status_channel

//--- hw/power_fault_status_reporting.sv
// fault and warning status register bank of a two-channel power controller
`timescale 1ns/1ns
`include "pwr_status_consts.svh"
// Functional notes
// - external undertemperature fault when sensed temperature falls below the per-channel trip level
// - per-channel one-byte fault summary at 0x78, chosen by page
// - summary bit 6 reads 1 whenever the channel delivers no output power
// - summary bits 5,4,2,1 flag overvoltage, overcurrent, temperature, comm/logic
// - unsupported status bit positions always read 0
// - summary bit 0 set for a fault not covered by bits 7..1
// - bit 7 set when unable to respond; only bits 7,0 alert, write-1 clears
// - 16-bit summary word at 0x79, low byte equals the summary byte
// - word bits 15..12 flag voltage, current, input, vendor groups
// - word bit 11 reads 1 while power-good is false
// - output voltage flags at 0x7A, bits 7..1, all may alert
// - host clears an output voltage flag by writing 1 to it
// - output current flags at 0x7B, bits 7 and 5, alert and write-1 clear
// - input flags bits 7,5,3; only bit 7 alerts and clears by write-1
// - input flags at 0x7C shared by both channels, not paged
// - thermal flags at 0x7D, bits 7,6,4, alert and write-1 clear
// - writing 1 to a current or thermal flag clears only that bit
// - comm/memory/logic flags at 0x7E, shared, read and write
// - send-byte command 0x03 clears all set fault bits
// - read-only pad state word at 0xE5, shared
// - read-only unpaged common device flags at 0xEF
// - a fault still present after clearing sets again and re-asserts alert
// - any vendor flag sets word bit 12 and may alert
// - overtemperature warning sets summary temperature bit and thermal warning bit
// - comm/logic bit 7 flags bad command, bit 6 bad data
module power_fault_status_reporting
	import pwr_status_pkg::*;
#(
	parameter int CHANNELS = 2
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	input wire logic cmd_page,
	input wire logic [1:0][7:0] voltage_group_flag_cond,
	input wire logic [1:0][7:0] current_group_flag_cond,
	input wire logic [1:0][7:0] thermal_cond,
	input wire logic [1:0][7:0] vendor_cond,
	input wire logic [1:0] busy_evt,
	input wire logic [1:0] unlisted_evt,
	input wire logic [1:0] output_on,
	input wire logic [1:0] power_good,
	input wire logic [1:0][15:0] ext_temp,
	input wire logic [7:0] supply_cond,
	input wire logic [7:0] cml_cond,
	input wire logic [15:0] pad_pins,
	input wire logic [7:0] common_cond,
	input wire logic ecc_clean,
	output status_word_t rd_data,
	output logic rd_valid,
	output logic alert_n
);
	generate
		if (CHANNELS != 2) begin : g_bad_channels
			$error("power_fault_status_reporting serves exactly two channels");
		end
	endgenerate

	localparam int ASYNC_W = 113;

	// analog detectors and pins are asynchronous: two flops before use, except ext_temp, which feeds the channels unsynchronised
	logic [ASYNC_W-1:0] async_in;
	logic [ASYNC_W-1:0] sync_a;
	logic [ASYNC_W-1:0] sync_b;

	assign async_in = {voltage_group_flag_cond, current_group_flag_cond, thermal_cond, vendor_cond, busy_evt, unlisted_evt,
		output_on, power_good, supply_cond, cml_cond, pad_pins, common_cond, ecc_clean};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync_a <= '0;
		end else begin
			sync_a <= async_in;
		end
	end

	// only the second stage is read, the first may still be resolving
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync_b <= '0;
		end else begin
			sync_b <= sync_a;
		end
	end

	logic [1:0][7:0] s_voltage_group_flag;
	logic [1:0][7:0] s_current_group_flag;
	logic [1:0][7:0] s_thermal;
	logic [1:0][7:0] s_vendor;
	logic [1:0] s_busy;
	logic [1:0] s_unlisted;
	logic [1:0] s_on;
	logic [1:0] s_pg;
	flag_byte_t s_supply;
	flag_byte_t s_cml;
	status_word_t s_pads;
	flag_byte_t s_common;
	logic s_ecc;

	assign {s_voltage_group_flag, s_current_group_flag, s_thermal, s_vendor, s_busy, s_unlisted, s_on, s_pg, s_supply,
		s_cml, s_pads, s_common, s_ecc} = sync_b;

	// command decode
	logic wr;
	logic rd;
	logic hit_clear;
	logic hit_trip;
	logic hit_short;
	logic hit_long;
	logic hit_voltage_group_flag;
	logic hit_current_group_flag;
	logic hit_input;
	logic hit_thermal;
	logic hit_cml;
	logic hit_vendor;
	logic hit_ecc;
	logic hit_pads;
	logic hit_common;
	logic hit_ro;
	logic hit_any;
	logic bad_cmd;
	logic bad_data;
	logic clear_all;

	assign wr = cmd_valid & cmd_write;
	assign rd = cmd_valid & ~cmd_write;
	assign hit_clear = cmd_code == `CMD_CLEAR_ALL;
	assign hit_trip = cmd_code == `CMD_LOW_TRIP;
	assign hit_short = cmd_code == `CMD_SUM_SHORT;
	assign hit_long = cmd_code == `CMD_SUM_LONG;
	assign hit_voltage_group_flag = cmd_code == `CMD_VOLTAGE_GROUP_FLAG;
	assign hit_current_group_flag = cmd_code == `CMD_CURRENT_GROUP_FLAG;
	assign hit_input = cmd_code == `CMD_INPUT;
	assign hit_thermal = cmd_code == `CMD_THERMAL;
	assign hit_cml = cmd_code == `CMD_CML;
	assign hit_vendor = cmd_code == `CMD_VENDOR;
	assign hit_ecc = cmd_code == `CMD_ECC_INFO;
	assign hit_pads = cmd_code == `CMD_PADS;
	assign hit_common = cmd_code == `CMD_COMMON;
	assign hit_ro = hit_ecc | hit_pads | hit_common;
	assign hit_any = hit_clear | hit_trip | hit_short | hit_long | hit_voltage_group_flag | hit_current_group_flag
		| hit_input | hit_thermal | hit_cml | hit_vendor | hit_ro;
	assign clear_all = wr & hit_clear;
	// reading the clear command is as wrong as an unknown code
	assign bad_cmd = cmd_valid & (~hit_any | (rd & hit_clear));
	assign bad_data = wr & hit_ro;

	// per-channel banks
	logic [1:0][7:0] voltage_group_flag_flags;
	logic [1:0][7:0] current_group_flag_flags;
	logic [1:0][7:0] thermal_flags;
	logic [1:0][7:0] vendor_flags;
	logic [1:0] busy_flag;
	logic [1:0] unlisted_flag;
	logic [1:0][15:0] trip_level;
	logic [1:0][7:0] sum_short;
	logic [1:0][7:0] sum_high;
	logic [1:0] ch_alert;

	flag_byte_t supply_flags;
	flag_byte_t comm_memory_logic_flags;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			logic sel;
			logic wr_sum_ch;
			logic wr_voltage_group_flag_ch;
			logic wr_current_group_flag_ch;
			logic wr_therm_ch;
			logic wr_vendor_ch;
			logic wr_trip_ch;
			logic voltage_group_flag_any;
			logic current_group_flag_any;
			logic therm_any;
			logic vendor_any;

			// the page travels with each command, so no stale page can steer a write
			assign sel = wr & (cmd_page == 1'(ch));
			assign wr_sum_ch = sel & (hit_short | hit_long);
			assign wr_voltage_group_flag_ch = sel & hit_voltage_group_flag;
			assign wr_current_group_flag_ch = sel & hit_current_group_flag;
			assign wr_therm_ch = sel & hit_thermal;
			assign wr_vendor_ch = sel & hit_vendor;
			assign wr_trip_ch = sel & hit_trip;
			assign voltage_group_flag_any = |voltage_group_flag_flags[ch];
			assign current_group_flag_any = |current_group_flag_flags[ch];
			assign therm_any = |thermal_flags[ch];
			assign vendor_any = |vendor_flags[ch];

			status_channel u_chan (
				.clk(clk),
				.resetn(resetn),
				.clear_all(clear_all),
				.wdata(cmd_wdata),
				.wr_sum(wr_sum_ch),
				.wr_voltage_group_flag(wr_voltage_group_flag_ch),
				.wr_current_group_flag(wr_current_group_flag_ch),
				.wr_thermal(wr_therm_ch),
				.wr_vendor(wr_vendor_ch),
				.wr_trip(wr_trip_ch),
				.voltage_group_flag_cond(s_voltage_group_flag[ch]),
				.current_group_flag_cond(s_current_group_flag[ch]),
				.thermal_cond(s_thermal[ch]),
				.vendor_cond(s_vendor[ch]),
				.busy_evt(s_busy[ch]),
				.unlisted_evt(s_unlisted[ch]),
				.ext_temp(ext_temp[ch]),
				.voltage_group_flag_flags(voltage_group_flag_flags[ch]),
				.current_group_flag_flags(current_group_flag_flags[ch]),
				.thermal_flags(thermal_flags[ch]),
				.vendor_flags(vendor_flags[ch]),
				.busy_flag(busy_flag[ch]),
				.unlisted_flag(unlisted_flag[ch]),
				.low_temp_trip_level(trip_level[ch])
			);

			// summary byte: live OR of detail flags plus two sticky bits
			assign sum_short[ch] = {busy_flag[ch],
				~s_on[ch],
				voltage_group_flag_flags[ch][`OVERVOLTAGE_TRIP_FLAG_FAULT],
				current_group_flag_flags[ch][`OVERCURRENT_TRIP_FLAG_FAULT],
				1'b0,
				therm_any,
				|comm_memory_logic_flags,
				unlisted_flag[ch]};
			assign sum_high[ch] = {voltage_group_flag_any,
				current_group_flag_any,
				|supply_flags,
				vendor_any,
				~s_pg[ch],
				3'b000};
			assign ch_alert[ch] = busy_flag[ch] | unlisted_flag[ch] | voltage_group_flag_any
				| current_group_flag_any | therm_any | vendor_any;
		end
	endgenerate

	// shared flag bytes
	logic wr_input;
	logic wr_cml;
	flag_byte_t supply_drop;
	flag_byte_t next_supply;
	flag_byte_t cml_in;
	flag_byte_t cml_drop;
	flag_byte_t next_cml;

	assign wr_input = wr & hit_input;
	assign wr_cml = wr & hit_cml;
	// input bit 5 only leaves on a global clear; bit 3 is a live state
	assign supply_drop = clear_all ? 8'hFF
		: (wr_input ? (cmd_wdata[7:0] & `INPUT_W1C_MASK) : 8'h00);
	assign next_supply = ((supply_flags & ~supply_drop) | s_supply) & `INPUT_MASK;
	assign cml_in = (s_cml | (8'(bad_cmd) << `CML_BAD_CMD) | (8'(bad_data) << `CML_BAD_DATA))
		& `CML_MASK;
	assign cml_drop = clear_all ? 8'hFF
		: (wr_cml ? (cmd_wdata[7:0] & `CML_MASK) : 8'h00);
	assign next_cml = ((comm_memory_logic_flags & ~cml_drop) | cml_in) & `CML_MASK;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			supply_flags <= 8'h00;
		end else begin
			supply_flags <= next_supply;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			comm_memory_logic_flags <= 8'h00;
		end else begin
			comm_memory_logic_flags <= next_cml;
		end
	end

	logic [7:0] input_view;
	assign input_view = supply_flags | (8'(s_supply[`INPUT_LOW_OFF]) << `INPUT_LOW_OFF);

	// alert is driven only by alert-capable flags
	logic next_alert_n;
	assign next_alert_n = ~((|ch_alert) | supply_flags[7] | (|comm_memory_logic_flags));

	flag_byte_t common_device_flags;
	assign common_device_flags = (s_common & `COMMON_MASK)
		| (8'(alert_n) << `COMMON_NO_ALERT);

	status_word_t pad_state_word;
	status_word_t ecc_info_word;
	assign pad_state_word = s_pads & `PADS_MASK;
	assign ecc_info_word = {10'h000, s_ecc, 5'h00} & `ECC_INFO_MASK;

	// read mux; paged registers follow the page given with the command
	logic pg;
	status_word_t next_rd_data;
	assign pg = cmd_page;
	assign next_rd_data =
		hit_short ? {8'h00, sum_short[pg]} :
		hit_long ? {sum_high[pg], sum_short[pg]} :
		hit_voltage_group_flag ? {8'h00, voltage_group_flag_flags[pg]} :
		hit_current_group_flag ? {8'h00, current_group_flag_flags[pg]} :
		hit_input ? {8'h00, input_view} :
		hit_thermal ? {8'h00, thermal_flags[pg]} :
		hit_cml ? {8'h00, comm_memory_logic_flags} :
		hit_vendor ? {8'h00, vendor_flags[pg]} :
		hit_trip ? trip_level[pg] :
		hit_pads ? pad_state_word :
		hit_common ? {8'h00, common_device_flags} :
		hit_ecc ? ecc_info_word :
		16'h0000;

	// one pulse per read; a write never answers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd;
		end
	end

	// held between reads so a slow transaction layer may fetch it late
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_data <= 16'h0000;
		end else if (rd) begin
			rd_data <= next_rd_data;
		end
	end

	// registered so the pin never glitches while flags settle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			alert_n <= 1'b1;
		end else begin
			alert_n <= next_alert_n;
		end
	end
endmodule // power_fault_status_reporting

//--- dv/power_fault_status_reporting_props.sv
// concurrent checks on the status bank command and read port
`timescale 1ns/1ns
module power_fault_status_reporting_props
	import pwr_status_pkg::*;
#(
	parameter int CHANNELS = 2
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire status_word_t rd_data,
	input wire logic rd_valid,
	input wire logic alert_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_read(logic [7:0] c);
		cmd_valid && !cmd_write && cmd_code == c;
	endsequence
	sequence s_voltage_group_flag_seen;
		s_read(8'h7A) ##1 (rd_data[7:1] != 7'h00);
	endsequence
	AST_READ_ANSWER: assert property (cmd_valid && !cmd_write |=> rd_valid)
		else $error("read not answered next cycle");
	AST_WRITE_SILENT: assert property (cmd_valid && cmd_write |=> !rd_valid)
		else $error("write gave a read answer");
	AST_NO_STRAY: assert property (rd_valid |-> $past(cmd_valid && !cmd_write))
		else $error("answer without a read");
	AST_BYTE_UNUSED: assert property (s_read(8'h78) |=> rd_data[15:8] == 8'h00 && !rd_data[3])
		else $error("summary byte unused bits set");
	AST_WORD_UNUSED: assert property (s_read(8'h79) |=> rd_data[10:8] == 3'h0 && !rd_data[3])
		else $error("summary word unused bits set");
	AST_CURRENT_GROUP_FLAG_MASK: assert property (s_read(8'h7B) |=> (rd_data & 16'hFF5F) == 16'h0000)
		else $error("current flags unused bits set");
	AST_INPUT_MASK: assert property (s_read(8'h7C) |=> (rd_data & 16'hFF57) == 16'h0000)
		else $error("input flags unused bits set");
	AST_THERMAL_MASK: assert property (s_read(8'h7D) |=> (rd_data & 16'hFF2F) == 16'h0000)
		else $error("thermal flags unused bits set");
	AST_PADS_MASK: assert property (s_read(8'hE5) |=> rd_data[13:12] == 2'h0)
		else $error("pad word bits 13:12 set");
	AST_COMMON_MASK: assert property (s_read(8'hEF) |=> (rd_data & 16'hFF05) == 16'h0000)
		else $error("common flags unused bits set");
	AST_VOLTAGE_GROUP_FLAG_ALERT: assert property (s_voltage_group_flag_seen |-> !alert_n)
		else $error("voltage flag set without alert");
endmodule // power_fault_status_reporting_props

bind power_fault_status_reporting power_fault_status_reporting_props #(.CHANNELS(CHANNELS)) u_props (
	.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
	.cmd_code(cmd_code), .rd_data(rd_data), .rd_valid(rd_valid), .alert_n(alert_n));

//--- dv/pmbus_host_model.sv
// host side model issuing one-beat commands to the status bank
`timescale 1ns/1ns
module pmbus_host_model
	import pwr_status_pkg::*;
(
	input wire logic clk,
	output logic cmd_valid,
	output logic cmd_write,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_wdata,
	output logic cmd_page,
	input wire status_word_t rd_data,
	input wire logic rd_valid
);
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
		cmd_page = 1'b0;
	end
	// idle fields are scrambled so a stale code never passes for a live one
	task automatic issue(input logic wr, input logic [7:0] c, input logic p, input logic [15:0] d);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_code = c;
		cmd_page = p;
		cmd_wdata = d;
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_code = ~c;
		cmd_page = ~p;
		cmd_wdata = ~d;
	endtask
	// ones clear flags, zeros leave them; code 03 with no data clears all
	task automatic host_write(input logic [7:0] c, input logic p, input logic [15:0] d);
		issue(1'b1, c, p, d);
	endtask
	task automatic host_read(input logic [7:0] c, input logic p, output status_word_t v, output logic ok);
		issue(1'b0, c, p, 16'h0000);
		ok = rd_valid;
		v = rd_data;
	endtask
endmodule // pmbus_host_model

//--- dv/power_fault_status_reporting_tb.sv
// self-checking bench for the power status bank
`timescale 1ns/1ns
module power_fault_status_reporting_tb;
	import pwr_status_pkg::*;
	typedef struct {logic [7:0] code; logic pg; status_word_t exp;} row_t;
	logic clk, resetn, cmd_valid, cmd_write, cmd_page, ecc_clean, ok, rd_valid, alert_n;
	logic [7:0] cmd_code, supply_cond, cml_cond, common_cond;
	logic [15:0] cmd_wdata, pad_pins;
	logic [1:0][7:0] voltage_group_flag_cond, current_group_flag_cond, thermal_cond, vendor_cond;
	logic [1:0] busy_evt, unlisted_evt, output_on, power_good;
	logic [1:0][15:0] ext_temp;
	status_word_t rd_data, v;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	row_t rows [25] = '{
		'{8'h78, 1'h0, 16'h0000}, '{8'h79, 1'h0, 16'h0000},
		'{8'h79, 1'h1, 16'h0840}, '{8'h78, 1'h1, 16'h0040},
		'{8'h7A, 1'h0, 16'h0000}, '{8'h7B, 1'h0, 16'h0000},
		'{8'h7C, 1'h1, 16'h0000}, '{8'h7D, 1'h0, 16'h0000},
		'{8'h7E, 1'h1, 16'h0000}, '{8'h80, 1'h0, 16'h0000},
		'{8'hB6, 1'h0, 16'h0020}, '{8'hE5, 1'h1, 16'hCFFF},
		'{8'hEF, 1'h0, 16'h00FA}, '{8'h53, 1'h1, 16'hE580},
		'{8'h7A, 1'h0, 16'h00FE}, '{8'h7A, 1'h1, 16'h0000},
		'{8'h7B, 1'h0, 16'h00A0}, '{8'h7D, 1'h0, 16'h00D0},
		'{8'h80, 1'h0, 16'h00FB}, '{8'h7C, 1'h1, 16'h00A8},
		'{8'h7E, 1'h1, 16'h0002}, '{8'h78, 1'h0, 16'h00B7},
		'{8'h79, 1'h0, 16'hF0B7}, '{8'h79, 1'h1, 16'h2002},
		'{8'hEF, 1'h0, 16'h007A}};
	power_fault_status_reporting #(.CHANNELS(2)) u_power_fault_status_reporting (
		.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_page(cmd_page),
		.voltage_group_flag_cond(voltage_group_flag_cond), .current_group_flag_cond(current_group_flag_cond), .thermal_cond(thermal_cond),
		.vendor_cond(vendor_cond), .busy_evt(busy_evt), .unlisted_evt(unlisted_evt),
		.output_on(output_on), .power_good(power_good), .ext_temp(ext_temp),
		.supply_cond(supply_cond), .cml_cond(cml_cond), .pad_pins(pad_pins),
		.common_cond(common_cond), .ecc_clean(ecc_clean), .rd_data(rd_data),
		.rd_valid(rd_valid), .alert_n(alert_n));
	pmbus_host_model u_pmbus_host_model (.clk(clk), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
		.cmd_page(cmd_page), .rd_data(rd_data), .rd_valid(rd_valid));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// the whole run is under two hundred cycles, so this only trips on a hang
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	task automatic check(input status_word_t got, input status_word_t exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] c, input logic p, input status_word_t e);
		u_pmbus_host_model.host_read(c, p, v, ok);
		check({15'h0000, ok}, 16'h0001);
		check(v, e);
	endtask
	initial begin
		resetn = 1'b0;
		ecc_clean = 1'b1;
		pad_pins = 16'hFFFF;
		common_cond = 8'hFF;
		supply_cond = 8'h00;
		cml_cond = 8'h00;
		voltage_group_flag_cond = '0;
		current_group_flag_cond = '0;
		thermal_cond = '0;
		vendor_cond = '0;
		busy_evt = 2'h0;
		unlisted_evt = 2'h0;
		output_on = 2'h1;
		power_good = 2'h1;
		ext_temp = {2{16'hEAA8}};
		repeat (20) @(negedge clk);
		check({14'h0000, rd_valid, alert_n}, 16'h0001);
		check(rd_data, 16'h0000);
		resetn = 1'b1;
		$display("test reset done");
		repeat (4) @(negedge clk);
		for (int i = 0; i < 14; i++) rd(rows[i].code, rows[i].pg, rows[i].exp);
		$display("test idle rows done");
		voltage_group_flag_cond[0] = 8'hFF;
		current_group_flag_cond[0] = 8'hFF;
		thermal_cond[0] = 8'hFF;
		vendor_cond[0] = 8'hFF;
		busy_evt[0] = 1'b1;
		unlisted_evt[0] = 1'b1;
		supply_cond = 8'hA8;
		cml_cond = 8'h02;
		output_on = 2'h3;
		power_good = 2'h3;
		ext_temp[0] = 16'hE480;
		repeat (6) @(negedge clk);
		for (int i = 14; i < 25; i++) rd(rows[i].code, rows[i].pg, rows[i].exp);
		$display("test fault rows done");
		// overcurrent stays live so the clear must see it set again
		voltage_group_flag_cond = '0;
		current_group_flag_cond = {8'h00, 8'hA0};
		thermal_cond = '0;
		vendor_cond = '0;
		busy_evt = 2'h0;
		unlisted_evt = 2'h0;
		supply_cond = 8'h00;
		cml_cond = 8'h00;
		ext_temp = {2{16'hEAA8}};
		repeat (6) @(negedge clk);
		u_pmbus_host_model.host_write(8'h7A, 1'h0, 16'h0080);
		rd(8'h7A, 1'h0, 16'h007E);
		u_pmbus_host_model.host_write(8'h7D, 1'h0, 16'h0000);
		rd(8'h7D, 1'h0, 16'h00D0);
		u_pmbus_host_model.host_write(8'h7D, 1'h0, 16'h0010);
		rd(8'h7D, 1'h0, 16'h00C0);
		u_pmbus_host_model.host_write(8'h78, 1'h0, 16'h0081);
		rd(8'h78, 1'h0, 16'h0016);
		u_pmbus_host_model.host_write(8'h7C, 1'h1, 16'h00A8);
		rd(8'h7C, 1'h0, 16'h0020);
		u_pmbus_host_model.host_write(8'h53, 1'h1, 16'h1234);
		rd(8'h53, 1'h1, 16'h1234);
		rd(8'h53, 1'h0, 16'hE580);
		rd(8'h7D, 1'h1, 16'h0010);
		u_pmbus_host_model.host_write(8'h53, 1'h1, 16'hE580);
		u_pmbus_host_model.host_write(8'h80, 1'h0, 16'h0003);
		rd(8'h80, 1'h0, 16'h00F8);
		$display("test write one clear done");
		u_pmbus_host_model.host_write(8'hE5, 1'h0, 16'hFFFF);
		rd(8'h7E, 1'h0, 16'h0042);
		u_pmbus_host_model.host_read(8'h03, 1'h0, v, ok);
		rd(8'h7E, 1'h1, 16'h00C2);
		u_pmbus_host_model.host_write(8'h7E, 1'h0, 16'h0040);
		rd(8'h7E, 1'h1, 16'h0082);
		u_pmbus_host_model.host_write(8'h03, 1'h0, 16'h0000);
		rd(8'h7B, 1'h0, 16'h00A0);
		rd(8'h7E, 1'h0, 16'h0000);
		rd(8'h7A, 1'h0, 16'h0000);
		check({15'h0000, alert_n}, 16'h0000);
		current_group_flag_cond = '0;
		repeat (5) @(negedge clk);
		u_pmbus_host_model.host_write(8'h03, 1'h0, 16'h0000);
		repeat (2) @(negedge clk);
		check({15'h0000, alert_n}, 16'h0001);
		$display("test clear all done");
		// a trip level above the sensed temperature raises a fault that reset must wipe
		u_pmbus_host_model.host_write(8'h53, 1'h0, 16'h0123);
		rd(8'h53, 1'h0, 16'h0123);
		resetn = 1'b0;
		@(negedge clk);
		check({14'h0000, rd_valid, alert_n}, 16'h0001);
		check(rd_data, 16'h0000);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		rd(8'h53, 1'h0, 16'hE580);
		rd(8'h7D, 1'h0, 16'h0000);
		$display("test reset in run done");
		report_and_stop();
	end
endmodule // power_fault_status_reporting_tb
